// >>> dv/bus_master_model.sv
// Register bus master model that polls the configuration block
`timescale 1ns/1ps
module bus_master_model (
  input wire logic ref_clk,
  output logic reg_rd,
  output logic reg_wr,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata_q,
  input wire logic reg_ack_q,
  input wire logic reg_err_q
);
  // ========
  // Idle bus
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
  end

  // one word access
  // Strobe lasts one cycle; the answer stands only in the next one, so sample it there
  task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] rdata, output logic ack, output logic err);
    @(negedge ref_clk);
    reg_rd = ~wr;
    reg_wr = wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    rdata = reg_rdata_q;
    ack = reg_ack_q;
    err = reg_err_q;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = ~a; // Released lines never keep the last value
    reg_wdata = ~d;
  endtask

  // both halves one request
  // Back-to-back reads so the two halves come from one sample
  task automatic read_float(input logic [15:0] a, output logic [31:0] v, output logic ok);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    v[31:16] = reg_rdata_q;
    ok = reg_ack_q & ~reg_err_q;
    reg_addr = a + 16'h0001;
    @(negedge ref_clk);
    v[15:0] = reg_rdata_q;
    ok = ok & reg_ack_q & ~reg_err_q;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
  endtask
endmodule

// >>> dv/sensor_switch_config_and_bus_id_tb.sv
// Self-checking testbench of the switch decode and bus identity block
`timescale 1ns/1ps
module sensor_switch_config_and_bus_id_tb;
  // Identity texts are arbitrary
  localparam logic [127:0] SER = "SN4711ABCDEFGH12";
  localparam logic [127:0] NAME = "DIFFPRESS TEST  ";
  localparam logic [6:0] PCT [4] = '{7'h64, 7'h4b, 7'h32, 7'h19};
  localparam logic [15:0] RESP [4] = '{16'h0032, 16'h01f4, 16'h07d0, 16'h0fa0};
  logic ref_clk, rstn, bacnet_mode, reg_rd, reg_wr, reg_ack_q, reg_err_q, ack, err, ok;
  logic [9:0] sw; // Bit 0 first range switch up to bit 9 spare switch
  logic [7:0] stored_switches, node_addr_switch, node_addr_q;
  logic signed [31:0] dp_pa;
  logic [31:0] dp_float, fv;
  logic [15:0] norm_mv, norm_ua, reg_addr, reg_wdata, reg_rdata_q, rd;
  logic [15:0] response_ms_q, voltage_mv_q, current_ua_q;
  logic [6:0] range_pct_q;
  logic [2:0] baud_idx_q;
  logic backlight_on_q, stop2_q, cfg_ready_q;
  sensor_cfg_pkg::unit_e unit_q;
  sensor_cfg_pkg::out_pair_e out_pair_q;
  sensor_cfg_pkg::level_e level_q;
  sensor_cfg_pkg::parity_e parity_q;
  int failures, cmp_count;

  // ========
  // Design and bus master
  sensor_config #(.SERIAL_TEXT(SER), .SENSOR_NAME(NAME), .FW_MAJOR(8'h02), .FW_MINOR(8'h07)) DUT (
    .ref_clk, .rstn, .range_select_bit0(sw[0]), .range_select_bit1(sw[1]),
    .response_select_bit0(sw[2]), .response_select_bit1(sw[3]), .unit_select_bit0(sw[4]),
    .unit_select_bit1(sw[5]), .backlight_off_switch(sw[6]), .output_range_switch(sw[7]),
    .settings_source_switch(sw[8]), .spare_switch(sw[9]), .stored_switches, .node_addr_switch,
    .bacnet_mode, .dp_pa, .dp_float, .norm_mv, .norm_ua, .reg_rd, .reg_wr, .reg_addr,
    .reg_wdata, .unit_q, .backlight_on_q, .out_pair_q, .range_pct_q, .response_ms_q, .level_q,
    .voltage_mv_q, .current_ua_q, .node_addr_q, .baud_idx_q, .parity_q, .stop2_q, .cfg_ready_q,
    .reg_rdata_q, .reg_ack_q, .reg_err_q);
  bus_master_model partner (.ref_clk, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata_q,
    .reg_ack_q, .reg_err_q);

  // ========
  // Clock and helpers
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Switches only count at the first edge after release, so each setting needs a reset
  task automatic do_reset(input logic [9:0] s, input logic [7:0] st, input logic [7:0] a);
    @(negedge ref_clk);
    rstn = 1'b0;
    sw = s;
    stored_switches = st;
    node_addr_switch = a;
    repeat (16) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (3) @(negedge ref_clk);
    check(cfg_ready_q, 1);
  endtask

  task automatic lvl(input logic signed [31:0] dp, input logic [1:0] lv, input logic [15:0] mv,
                     input logic [15:0] ua);
    dp_pa = dp;
    repeat (2) @(negedge ref_clk);
    check(level_q, lv);
    check({voltage_mv_q, current_ua_q}, {mv, ua});
  endtask

  task automatic wr_chk(input logic [15:0] a, input logic [15:0] d, input logic e);
    partner.access(1'b1, a, d, rd, ack, err);
    check({ack, err}, {1'b1, e});
    @(negedge ref_clk);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp, input logic e);
    partner.access(1'b0, a, 16'h0000, rd, ack, err);
    check({ack, err}, {1'b1, e});
    if (!e) check(rd, exp);
  endtask

  // ========
  // Scenarios
  task automatic t_decode;
    for (int i = 0; i < 4; i++) begin
      do_reset({i[0], 1'b0, i[1], i[0], i[1:0], i[1:0], i[1:0]}, 8'h00, 8'h00);
      check(unit_q, i);
      check(range_pct_q, PCT[i]);
      check(response_ms_q, RESP[i]);
      check(backlight_on_q, !i[0]);
      check(out_pair_q, i[1]);
      sw = ~sw; // Later switch moves must not reach the outputs
      repeat (2) @(negedge ref_clk);
      check({unit_q, range_pct_q}, {i[1:0], PCT[i]});
    end
  endtask

  task automatic t_levels;
    // Only the spare switch on: every setting must stay at its default
    do_reset(10'h200, 8'h00, 8'h00);
    check({unit_q, range_pct_q, response_ms_q}, {2'd0, 7'h64, 16'h0032});
    check({backlight_on_q, out_pair_q}, 2'b10);
    lvl(-50, 2'd0, 16'h1234, 16'h0abc);
    lvl(-51, 2'd1, 16'(-500), 16'd3200);
    lvl(1050, 2'd0, 16'h1234, 16'h0abc);
    lvl(1051, 2'd2, 16'd10500, 16'd20800);
    // Stored image all ones: kPa, 25 percent, 4 s, backlight off, 5 V pair
    do_reset(10'h100, 8'hff, 8'h00);
    check({unit_q, range_pct_q, response_ms_q}, {2'd3, 7'h19, 16'h0fa0});
    check({backlight_on_q, out_pair_q}, 2'b01);
    lvl(-12, 2'd0, 16'h1234, 16'h0abc);
    lvl(-13, 2'd1, 16'(-250), 16'(-1000));
    lvl(263, 2'd2, 16'd5250, 16'd21000);
    dp_pa = 0;
  endtask

  task automatic t_address;
    do_reset(10'h000, 8'h00, 8'h00);
    check(node_addr_q, 8'd43);
    wr_chk(16'h0000, 16'h000b, 1'b0);
    check(node_addr_q, 8'd11);
    wr_chk(16'h0000, 16'h00f7, 1'b0);
    wr_chk(16'h0000, 16'h00f8, 1'b1);
    wr_chk(16'h0000, 16'h0000, 1'b1);
    check(node_addr_q, 8'd247);
    do_reset(10'h000, 8'h00, 8'h8b);
    check(node_addr_q, 8'h8b);
    bacnet_mode = 1'b1;
    repeat (2) @(negedge ref_clk);
    check(node_addr_q, 8'h0b);
    wr_chk(16'h0000, 16'h0080, 1'b1);
    do_reset(10'h000, 8'h00, 8'h80);
    check(node_addr_q, 8'h00);
    bacnet_mode = 1'b0;
  endtask

  task automatic t_framing;
    do_reset(10'h000, 8'h00, 8'h00);
    check({baud_idx_q, parity_q, stop2_q}, {3'h0, 2'd2, 1'b0});
    wr_chk(16'h0001, 16'h002d, 1'b0);
    check({baud_idx_q, parity_q, stop2_q}, {3'h5, 2'd1, 1'b1});
    wr_chk(16'h0001, 16'h0006, 1'b1);
    wr_chk(16'h0001, 16'h0018, 1'b1);
    check({baud_idx_q, parity_q, stop2_q}, {3'h5, 2'd1, 1'b1});
    bacnet_mode = 1'b1;
    repeat (2) @(negedge ref_clk);
    check({baud_idx_q, parity_q, stop2_q}, {3'h5, 2'd0, 1'b0});
    wr_chk(16'h0001, 16'h0008, 1'b1);
    bacnet_mode = 1'b0;
  endtask

  task automatic t_ident;
    rd_chk(16'h0008, 16'h0207, 1'b0);
    rd_chk(16'h0000, SER[127:112], 1'b0);
    rd_chk(16'h0007, SER[15:0], 1'b0);
    rd_chk(16'h0009, NAME[127:112], 1'b0);
    rd_chk(16'h0010, NAME[15:0], 1'b0);
    rd_chk(16'h0011, 16'h0000, 1'b1);
    @(negedge ref_clk); // Answer of the last read has gone by now
    check({reg_ack_q, reg_err_q, reg_rdata_q}, 18'h0);
    wr_chk(16'h0008, 16'h0000, 1'b1);
    dp_float = 32'h4411_2233;
    dp_pa = -51;
    partner.read_float(16'h04be, fv, ok);
    check(ok, 1'b1);
    check(fv, 32'h4411_2233);
    rd_chk(16'h04be, 16'h4411, 1'b0);
    dp_float = 32'h5566_7788; // Low half must still be the earlier sample
    rd_chk(16'h04bf, 16'h2233, 1'b0);
    rd_chk(16'h100b, 16'hffcd, 1'b0);
    dp_pa = 40000;
    rd_chk(16'h100b, 16'h7fff, 1'b0);
    dp_pa = -40000;
    rd_chk(16'h100b, 16'h8000, 1'b0);
    dp_pa = 0;
  endtask

  // ========
  // Main sequence and watchdog
  initial begin
    rstn = 1'b0;
    sw = 10'h000;
    stored_switches = 8'h00;
    node_addr_switch = 8'h00;
    bacnet_mode = 1'b0;
    dp_pa = 0;
    dp_float = 32'h0;
    norm_mv = 16'h1234;
    norm_ua = 16'h0abc;
    failures = 0;
    cmp_count = 0;
    t_decode();
    t_levels();
    t_address();
    t_framing();
    t_ident();
    final_report();
  end

  // Whole run is well under 1000 cycles; a hang is cut well after that
  initial begin
    #200us;
    failures++;
    final_report();
  end
endmodule

// >>> hdl/sensor_cfg.svh
// Offsets, reset values, field positions and output codes of the configuration block
`ifndef SENSOR_CFG_SVH
`define SENSOR_CFG_SVH

// ==========================================================
// Holding register word addresses
`define REG_SLAVE_ADDR 16'h0000
`define REG_FRAMING 16'h0001
`define REG_SERIAL_BASE 16'h0000
`define REG_SERIAL_LAST 16'h0007
`define REG_FW_VERSION 16'h0008
`define REG_NAME_BASE 16'h0009
`define REG_NAME_LAST 16'h0010
`define REG_FLT_PA_HI 16'h04be
`define REG_FLT_PA_LO 16'h04bf
`define REG_INT_PA 16'h100b

// ==========================================================
// Node address limits and reset value
`define DEFAULT_NODE_ADDR 8'h2b
`define MODBUS_ADDR_MIN 8'h01
`define MODBUS_ADDR_MAX 8'hf7
`define BACNET_ADDR_MAX 8'h7f
`define BACNET_ZERO_PAT 8'h80

// ==========================================================
// Framing word layout
`define FRM_BAUD_LSB 0
`define FRM_BAUD_MSB 2
`define FRM_PAR_LSB 3
`define FRM_PAR_MSB 4
`define FRM_STOP2_BIT 5
`define BAUD_IDX_MAX 3'h5

// ==========================================================
// Response times in ms and range shares in percent
`define RESP_MS_0 16'h0032
`define RESP_MS_1 16'h01f4
`define RESP_MS_2 16'h07d0
`define RESP_MS_3 16'h0fa0
`define RANGE_PCT_0 7'h64
`define RANGE_PCT_1 7'h4b
`define RANGE_PCT_2 7'h32
`define RANGE_PCT_3 7'h19

// ==========================================================
// Out-of-range output codes, mV and uA, two's complement
`define V10_UNDER 16'hfe0c
`define V5_UNDER 16'hff06
`define V10_OVER 16'h2904
`define V5_OVER 16'h1482
`define I420_UNDER 16'h0c80
`define I020_UNDER 16'hfc18
`define I420_OVER 16'h5140
`define I020_OVER 16'h5208

// ==========================================================
// Limit arithmetic: under if dp*80 < -fs*k, over if dp*80 > 21*fs*k
`define THR_SCALE 40'sh50
`define OVER_FACTOR 40'sh15

`endif

// >>> hdl/sensor_cfg_pkg.sv
// Types shared by the configuration block files
package sensor_cfg_pkg;
  typedef enum logic [1:0] {UNIT_PA, UNIT_MBAR, UNIT_INWC, UNIT_KPA} unit_e;
  typedef enum logic {PAIR_10V_4MA, PAIR_5V_0MA} out_pair_e;
  typedef enum logic [1:0] {LVL_NORMAL, LVL_UNDER, LVL_OVER} level_e;
  typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} parity_e;
  typedef enum logic {ST_SAMPLE, ST_RUN} cfg_state_e;
endpackage

// >>> hdl/sensor_config.sv
// Switch sampling, output codes, node address and holding registers of the transmitter
// Functional notes
// - Unit switches 00 Pa, first mbar, second inch WC, both kPa.
// - Backlight switch 0 turns backlight on, 1 turns it off.
// - Output switch 0: 0-10 V with 4-20 mA; 1: 0-5 V with 0-20 mA.
// - Source switch 0 uses switch bank, 1 uses stored software settings.
// - Tenth switch has no effect on anything.
// - Below -5 % of range drive the under-range code per output type.
// - Above 105 % of range drive the overload code per output type.
// - All address switches zero: stored node address is used.
// - Modbus: nonzero switches override stored address; valid 1 to 247.
// - BACnet: low seven switch bits give address; 1000 0000 means zero.
// - Stored node address defaults to 43.
// - Modbus framing: 8 bits, parity none/odd/even (even default), 1-2 stops.
// - BACnet framing: 8 bits, no parity, one stop bit.
// - Writes to word 0 set address, writes to word 1 set framing. Code ignores writes at the sampling edge after reset.
// - Words 0 to 7 read the serial number text.
// - Word 8 reads firmware version, major high byte, minor low byte.
// - Words from 9 read the sensor name text.
// - Pressure readable as two-word float and as signed 16-bit integer.
// - Response switches: 50 ms, 500 ms, 2 s, 4 s.
// - Range switches select 100, 75, 50 or 25 percent.
`timescale 1ns/1ps
`include "sensor_cfg.svh"
module sensor_config #(
  parameter int FULL_SCALE = 1000,
  parameter logic [127:0] SERIAL_TEXT = "SN00000000000000",
  parameter logic [127:0] SENSOR_NAME = "DPSENSOR        ",
  parameter logic [7:0] FW_MAJOR = 8'h01,
  parameter logic [7:0] FW_MINOR = 8'h00,
  parameter logic [2:0] DEFAULT_BAUD = 3'h0
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic range_select_bit0,
  input wire logic range_select_bit1,
  input wire logic response_select_bit0,
  input wire logic response_select_bit1,
  input wire logic unit_select_bit0,
  input wire logic unit_select_bit1,
  input wire logic backlight_off_switch,
  input wire logic output_range_switch,
  input wire logic settings_source_switch,
  input wire logic spare_switch,
  input wire logic [7:0] stored_switches,
  input wire logic [7:0] node_addr_switch,
  input wire logic bacnet_mode,
  input wire logic signed [31:0] dp_pa,
  input wire logic [31:0] dp_float,
  input wire logic [15:0] norm_mv,
  input wire logic [15:0] norm_ua,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output sensor_cfg_pkg::unit_e unit_q,
  output logic backlight_on_q,
  output sensor_cfg_pkg::out_pair_e out_pair_q,
  output logic [6:0] range_pct_q,
  output logic [15:0] response_ms_q,
  output sensor_cfg_pkg::level_e level_q,
  output logic [15:0] voltage_mv_q,
  output logic [15:0] current_ua_q,
  output logic [7:0] node_addr_q,
  output logic [2:0] baud_idx_q,
  output sensor_cfg_pkg::parity_e parity_q,
  output logic stop2_q,
  output logic cfg_ready_q,
  output logic [15:0] reg_rdata_q,
  output logic reg_ack_q,
  output logic reg_err_q
);
  // ==========================================================
  // Sampling state
  sensor_cfg_pkg::cfg_state_e state_q;
  logic [7:0] img_q;
  logic [7:0] sw_addr_q;
  logic [7:0] image_d;
  sensor_cfg_pkg::unit_e dec_unit;
  logic dec_backlight;
  sensor_cfg_pkg::out_pair_e dec_pair;
  logic [6:0] dec_pct;
  logic [2:0] dec_k;
  logic [15:0] dec_resp;

  // Pick switch bank or stored image
  // Spare switch left out of the image on purpose
  assign image_d = settings_source_switch ? stored_switches :
    {output_range_switch, backlight_off_switch, unit_select_bit1, unit_select_bit0,
     response_select_bit1, response_select_bit0, range_select_bit1, range_select_bit0};

  // Sample once after reset so settings stay still during traffic
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= sensor_cfg_pkg::ST_SAMPLE;
      img_q <= 8'h00;
      sw_addr_q <= 8'h00;
    end else if (state_q == sensor_cfg_pkg::ST_SAMPLE) begin
      img_q <= image_d;
      sw_addr_q <= node_addr_switch;
      state_q <= sensor_cfg_pkg::ST_RUN;
    end
  end

  switch_decode u_decode (
    .image(img_q),
    .unit(dec_unit),
    .backlight_on(dec_backlight),
    .out_pair(dec_pair),
    .range_pct(dec_pct),
    .range_k(dec_k),
    .response_ms(dec_resp)
  );

  // Decoded settings, loaded at the edge that raises ready
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      unit_q <= sensor_cfg_pkg::UNIT_PA;
      backlight_on_q <= 1'b1;
      out_pair_q <= sensor_cfg_pkg::PAIR_10V_4MA;
      range_pct_q <= `RANGE_PCT_0;
      response_ms_q <= `RESP_MS_0;
      cfg_ready_q <= 1'b0;
    end else begin
      unit_q <= dec_unit;
      backlight_on_q <= dec_backlight;
      out_pair_q <= dec_pair;
      range_pct_q <= dec_pct;
      response_ms_q <= dec_resp;
      cfg_ready_q <= (state_q == sensor_cfg_pkg::ST_RUN);
    end
  end

  // ==========================================================
  // Range limits and output codes
  logic signed [39:0] dp80;
  logic signed [39:0] span_k;
  sensor_cfg_pkg::level_e level_d;
  assign dp80 = 40'(dp_pa) * `THR_SCALE;
  assign span_k = 40'(FULL_SCALE) * $signed({37'h0, dec_k});

  // Under range, including reversed hoses; over range
  always_comb begin
    if (dp80 < -span_k) begin
      level_d = sensor_cfg_pkg::LVL_UNDER;
    end else if (dp80 > span_k * `OVER_FACTOR) begin
      level_d = sensor_cfg_pkg::LVL_OVER;
    end else begin
      level_d = sensor_cfg_pkg::LVL_NORMAL;
    end
  end

  function automatic logic [15:0] pick(input sensor_cfg_pkg::level_e lvl,
                                      input logic [15:0] norm,
                                      input logic [15:0] under,
                                      input logic [15:0] over);
    unique case (lvl)
      sensor_cfg_pkg::LVL_UNDER: pick = under;
      sensor_cfg_pkg::LVL_OVER: pick = over;
      default: pick = norm;
    endcase
  endfunction

  // Voltage and current driven together from the same level
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      level_q <= sensor_cfg_pkg::LVL_NORMAL;
      voltage_mv_q <= 16'h0000;
      current_ua_q <= 16'h0000;
    end else if (dec_pair == sensor_cfg_pkg::PAIR_10V_4MA) begin
      level_q <= level_d;
      voltage_mv_q <= pick(level_d, norm_mv, `V10_UNDER, `V10_OVER);
      current_ua_q <= pick(level_d, norm_ua, `I420_UNDER, `I420_OVER);
    end else begin
      level_q <= level_d;
      voltage_mv_q <= pick(level_d, norm_mv, `V5_UNDER, `V5_OVER);
      current_ua_q <= pick(level_d, norm_ua, `I020_UNDER, `I020_OVER);
    end
  end

  // ==========================================================
  // Stored communication settings
  logic [7:0] stored_addr_q;
  logic [2:0] stored_baud_q;
  sensor_cfg_pkg::parity_e stored_par_q;
  logic stored_stop2_q;
  logic [7:0] wr_addr_val;
  logic [2:0] wr_baud;
  logic [1:0] wr_par;
  logic addr_ok;
  logic frm_ok;

  assign wr_addr_val = reg_wdata[7:0];
  assign wr_baud = reg_wdata[`FRM_BAUD_MSB:`FRM_BAUD_LSB];
  assign wr_par = reg_wdata[`FRM_PAR_MSB:`FRM_PAR_LSB];
  assign addr_ok = (reg_wdata[15:8] == 8'h00) && (bacnet_mode ?
    (wr_addr_val <= `BACNET_ADDR_MAX) :
    (wr_addr_val >= `MODBUS_ADDR_MIN && wr_addr_val <= `MODBUS_ADDR_MAX));
  // Valid baud index and parity code; BACnet takes no parity
  assign frm_ok = (wr_baud <= `BAUD_IDX_MAX) && (wr_par != 2'h3) &&
    (!bacnet_mode || (wr_par == 2'h0 && !reg_wdata[`FRM_STOP2_BIT]));

  // Address and framing words taken when valid once the sampling cycle after reset is over
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stored_addr_q <= `DEFAULT_NODE_ADDR;
      stored_baud_q <= 3'h0;
      stored_par_q <= sensor_cfg_pkg::PAR_EVEN;
      stored_stop2_q <= 1'b0;
    end else if (state_q == sensor_cfg_pkg::ST_SAMPLE) begin
      stored_baud_q <= DEFAULT_BAUD;
    end else if (reg_wr && reg_addr == `REG_SLAVE_ADDR && addr_ok) begin
      stored_addr_q <= wr_addr_val;
    end else if (reg_wr && reg_addr == `REG_FRAMING && frm_ok) begin
      stored_baud_q <= wr_baud;
      stored_par_q <= sensor_cfg_pkg::parity_e'(wr_par);
      stored_stop2_q <= reg_wdata[`FRM_STOP2_BIT];
    end
  end

  // Zero switches defer to stored address; else switches rule
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      node_addr_q <= `DEFAULT_NODE_ADDR;
    end else if (sw_addr_q == 8'h00) begin
      node_addr_q <= stored_addr_q;
    end else if (bacnet_mode && sw_addr_q == `BACNET_ZERO_PAT) begin
      node_addr_q <= 8'h00;
    end else if (bacnet_mode) begin
      node_addr_q <= {1'b0, sw_addr_q[6:0]};
    end else begin
      node_addr_q <= sw_addr_q;
    end
  end

  // Modbus framing as stored; BACnet forced to none and one stop
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      baud_idx_q <= 3'h0;
      parity_q <= sensor_cfg_pkg::PAR_EVEN;
      stop2_q <= 1'b0;
    end else begin
      baud_idx_q <= stored_baud_q;
      parity_q <= bacnet_mode ? sensor_cfg_pkg::PAR_NONE : stored_par_q;
      stop2_q <= bacnet_mode ? 1'b0 : stored_stop2_q;
    end
  end

  // ==========================================================
  // Holding register reads
  logic [15:0] flt_lo_q;
  logic [15:0] int_pa;

  // Clamp so a huge reading does not wrap into the wrong sign
  assign int_pa = (dp_pa > 32'sh00007fff) ? 16'h7fff :
                  (dp_pa < -32'sh00008000) ? 16'h8000 : dp_pa[15:0];

  function automatic logic [15:0] text_word(input logic [127:0] txt, input logic [2:0] idx);
    text_word = txt[(7 - idx) * 16 +: 16];
  endfunction

  // High half read freezes the low half of the same sample
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flt_lo_q <= 16'h0000;
    end else if (reg_rd && reg_addr == `REG_FLT_PA_HI) begin
      flt_lo_q <= dp_float[15:0];
    end
  end

  // One-cycle answer; unknown words and bad writes answer with an error
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= 16'h0000;
      reg_ack_q <= 1'b0;
      reg_err_q <= 1'b0;
    end else begin
      reg_ack_q <= reg_rd | reg_wr;
      reg_err_q <= 1'b0;
      reg_rdata_q <= 16'h0000;
      if (reg_wr) begin
        reg_err_q <= !((reg_addr == `REG_SLAVE_ADDR && addr_ok) ||
                       (reg_addr == `REG_FRAMING && frm_ok));
      end else if (reg_rd) begin
        if (reg_addr <= `REG_SERIAL_LAST) begin
          reg_rdata_q <= text_word(SERIAL_TEXT, reg_addr[2:0]);
        end else if (reg_addr == `REG_FW_VERSION) begin
          reg_rdata_q <= {FW_MAJOR, FW_MINOR};
        end else if (reg_addr >= `REG_NAME_BASE && reg_addr <= `REG_NAME_LAST) begin
          reg_rdata_q <= text_word(SENSOR_NAME, 3'(reg_addr - `REG_NAME_BASE));
        end else if (reg_addr == `REG_FLT_PA_HI) begin
          reg_rdata_q <= dp_float[31:16];
        end else if (reg_addr == `REG_FLT_PA_LO) begin
          reg_rdata_q <= flt_lo_q;
        end else if (reg_addr == `REG_INT_PA) begin
          reg_rdata_q <= int_pa;
        end else begin
          reg_err_q <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence rd_fw_s;
    reg_rd && !reg_wr && reg_addr == `REG_FW_VERSION;
  endsequence
  sequence rd_flt_pair_s;
    (reg_rd && !reg_wr && reg_addr == `REG_FLT_PA_HI) ##1
    (reg_rd && !reg_wr && reg_addr == `REG_FLT_PA_LO);
  endsequence
  sequence bad_mb_addr_s;
    reg_wr && !bacnet_mode && reg_addr == `REG_SLAVE_ADDR && reg_wdata == 16'h0000;
  endsequence

  a_unit_kpa_map: assert property (cfg_ready_q && img_q[5:4] == 2'b11 |->
    unit_q == sensor_cfg_pkg::UNIT_KPA) else $error("kPa unit not decoded");
  a_backlight_pol: assert property (cfg_ready_q |-> backlight_on_q == !img_q[6])
    else $error("backlight polarity wrong");
  a_out_pair_sel: assert property (cfg_ready_q |-> out_pair_q == img_q[7])
    else $error("output pair wrong");
  a_cfg_held_stable: assert property (cfg_ready_q |=> $stable(img_q) && $stable(unit_q))
    else $error("settings moved after sampling");
  a_under_code_10v: assert property (level_q == sensor_cfg_pkg::LVL_UNDER &&
    $past(dec_pair) == sensor_cfg_pkg::PAIR_10V_4MA |->
    voltage_mv_q == `V10_UNDER && current_ua_q == `I420_UNDER)
    else $error("under-range code wrong");
  a_over_code_5v: assert property (level_q == sensor_cfg_pkg::LVL_OVER &&
    $past(dec_pair) == sensor_cfg_pkg::PAIR_5V_0MA |->
    voltage_mv_q == `V5_OVER && current_ua_q == `I020_OVER)
    else $error("overload code wrong");
  a_addr_from_store: assert property (sw_addr_q == 8'h00 |=>
    node_addr_q == $past(stored_addr_q)) else $error("stored address not used");
  a_mb_addr_reject: assert property (bad_mb_addr_s |=> reg_ack_q && reg_err_q)
    else $error("address zero accepted in Modbus");
  a_bacnet_zero_pat: assert property (bacnet_mode && sw_addr_q == `BACNET_ZERO_PAT
    |=> node_addr_q == 8'h00) else $error("BACnet zero pattern ignored");
  a_default_address: assert property (state_q == sensor_cfg_pkg::ST_SAMPLE &&
    node_addr_switch == 8'h00 |-> ##2 node_addr_q == `DEFAULT_NODE_ADDR)
    else $error("default address wrong");
  a_bacnet_framing: assert property (bacnet_mode |=>
    parity_q == sensor_cfg_pkg::PAR_NONE && !stop2_q) else $error("BACnet framing wrong");
  a_fw_word_read: assert property (rd_fw_s |=> reg_ack_q && !reg_err_q &&
    reg_rdata_q == {FW_MAJOR, FW_MINOR}) else $error("firmware word wrong");
  a_float_pair_read: assert property (rd_flt_pair_s |=>
    reg_rdata_q == $past(dp_float[15:0], 2)) else $error("float halves split");
endmodule

// >>> hdl/switch_decode.sv
// Combinational decode of the eight setting switches into configuration fields
`timescale 1ns/1ps
`include "sensor_cfg.svh"
module switch_decode (
  input wire logic [7:0] image,
  output sensor_cfg_pkg::unit_e unit,
  output logic backlight_on,
  output sensor_cfg_pkg::out_pair_e out_pair,
  output logic [6:0] range_pct,
  output logic [2:0] range_k,
  output logic [15:0] response_ms
);
  // ==========================================================
  // Helpers
  function automatic logic [6:0] pct_of(input logic [1:0] sel);
    unique case (sel)
      2'b00: pct_of = `RANGE_PCT_0;
      2'b01: pct_of = `RANGE_PCT_1;
      2'b10: pct_of = `RANGE_PCT_2;
      2'b11: pct_of = `RANGE_PCT_3;
    endcase
  endfunction

  function automatic logic [15:0] resp_of(input logic [1:0] sel);
    unique case (sel)
      2'b00: resp_of = `RESP_MS_0;
      2'b01: resp_of = `RESP_MS_1;
      2'b10: resp_of = `RESP_MS_2;
      2'b11: resp_of = `RESP_MS_3;
    endcase
  endfunction

  // ==========================================================
  // Field decode; bit 0 of each pair is the first switch
  always_comb begin
    range_pct = pct_of({image[1], image[0]});
    range_k = 3'h4 - {1'b0, image[1], image[0]};
    response_ms = resp_of({image[3], image[2]});
    unit = sensor_cfg_pkg::unit_e'({image[5], image[4]});
    backlight_on = ~image[6];
    out_pair = sensor_cfg_pkg::out_pair_e'(image[7]);
  end
endmodule
